// ---- src/link_sync_pkg.sv ----
// Purpose: Shared constants and types for the serial link sync block
// Assumes: Byte-wide register port, 12-bit register address
// Notes: Register offsets are the printed addresses
package link_sync_pkg;
  localparam logic [11:0] ADDR_DECIMATION_SELECT = 12'h140;
  localparam logic [11:0] ADDR_NCO_PHASE_LO = 12'h143;
  localparam logic [11:0] ADDR_NCO_PHASE_HI = 12'h145;
  localparam logic [11:0] ADDR_OUTPUT_FORMAT = 12'h146;
  localparam logic [11:0] ADDR_LANE_DRIVER_POWER = 12'h1e2;
  localparam logic [11:0] ADDR_SYNC_INPUT_CONFIG = 12'h1e7;
  localparam logic [11:0] ADDR_SYSREF_OPTIONS = 12'h1e8;
  localparam logic [11:0] ADDR_SYSREF_WINDOW = 12'h1ea;
  localparam logic [11:0] ADDR_LANE_TUNING = 12'h1ec;
  localparam logic [11:0] ADDR_PREEMPHASIS = 12'h1ef;
  localparam logic [11:0] ADDR_CAPTURE_PATH = 12'h2bb;
  localparam logic [11:0] ADDR_PLL_STATUS = 12'h2dc;
  localparam logic [7:0] RST_DECIMATION = 8'h10;
  localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h00;
  localparam logic [7:0] RST_LANE_POWER = 8'h03;
  localparam logic [7:0] RST_SYNC_CONFIG = 8'h00;
  localparam logic [7:0] RST_SYSREF_OPTIONS = 8'h00;
  localparam logic [7:0] RST_PREEMPHASIS = 8'h00;
  localparam logic [7:0] RST_CAPTURE_PATH = 8'h08;
  localparam logic [7:0] RST_LANE_TUNING = 8'h00;
  localparam logic [7:0] SYSREF_RX_OFF_VALUE = 8'h04;
  localparam int SYNC_LVDS_BIT = 2;
  localparam int CAPTURE_REFCLK_BIT = 3;
  localparam int OPT_ENABLE_BIT = 1;
  localparam int OPT_ONE_SHOT_BIT = 2;
  localparam int OPT_NCO_RESET_BIT = 5;
  localparam int WIN_EARLY_BIT = 0;
  localparam int WIN_LATE_BIT = 1;
  localparam int PLL_LOCK_BIT = 0;
  localparam int PLL_RANGE_ERR_BIT = 1;
  localparam int LANE_RATE_FACTOR = 40;
  localparam int LANE_RATE_MIN_MBPS = 3072;
  localparam int LANE_RATE_MAX_MBPS = 5333;
  localparam int ONE_LANE_MAX_KSPS = 133300;
  localparam int TWO_LANE_MIN_KSPS = 153600;
  localparam int FRAMES_MIN_F4 = 5;
  localparam int FRAMES_MIN_F2 = 9;
  localparam int SAMPLE_BITS = 16;
  localparam int SYSREF_MIN_CLKS = 2;
  localparam logic [7:0] PLL_LOCK_CYCLES = 8'h40;
  localparam logic [7:0] OCTET_K28_5 = 8'hbc;
  typedef enum {LINK_CGS, LINK_WAIT_LMFC, LINK_ILAS, LINK_DATA} link_state_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_type;
  typedef struct packed {
    logic [7:0] lane_power;
    logic [7:0] format;
    logic [7:0] preemph;
    logic [7:0] tuning;
    logic sync_lvds;
    logic sync_term_en;
    logic sysref_rx_en;
  } phy_ctrl_type;
endpackage

// ---- src/link_sync_ctrl.sv ----
// How it works
// - Sync input CMOS default, LVDS bit selectable
// - Lane drivers powered up after reset
// - Two's complement default, format register selectable
// - Preemphasis off by default, own register
// - Serializer PLL follows IQ rate, lane count
// - Read-only PLL lock flag in status
// - Lane rate must stay within limits
// - One lane carries forty times IQ rate
// - Two lanes carry twenty times IQ rate
// - IQ rate is clock over decimation
// - Multiframe length minimum per octets per frame
// - Both lanes form one shared link
// - Reference pulse aligns framing, filters, oscillator
// - First alignment uncertain by one clock
// - One-shot phase held until reset once sampled; continuous mode realigns on pulses outside the window
// - Capture path bit cleared before synchronizing
// - One-shot acts on second pulse only
// - Oscillator phase loaded on same pulse
// - Early/late windows tolerate continuous pulse jitter
// - Sync low sends comma, then alignment sequence
//
// Purpose: Register file, reference alignment and link start control
// Assumes: clk is the internal sample clock; reference pulse and sync are pins
// Notes: Converter clock rate in kHz is a parameter for rate checks
`timescale 1ns/100ps
module link_sync_ctrl #(
  parameter int CONV_CLK_KHZ = 3200000,
  parameter int FRAMES_PER_MF = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire link_sync_pkg::reg_req_type reg_req,
  output link_sync_pkg::reg_req_type dummy_unused_n,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sysref_in,
  input wire logic sync_request_in,
  output link_sync_pkg::phy_ctrl_type phy_ctrl,
  output logic two_lane_mode,
  output logic serdes_lock_flag,
  output logic [15:0] nco_phase_load,
  output logic nco_phase_strobe,
  output logic divider_reset,
  output logic [1:0] lane_send_comma,
  output logic [1:0] lane_send_ilas,
  output logic [7:0] lane_octet
);
  // Five-bit multiframe counter cannot serve more than 32 frames
  if (FRAMES_PER_MF < link_sync_pkg::FRAMES_MIN_F2 || FRAMES_PER_MF > 32) begin : g_bad_fpmf
    $error("Frames per multiframe out of range");
  end

  typedef struct packed {
    logic [7:0] dec;
    logic [7:0] ph_lo;
    logic [7:0] ph_hi;
    logic [7:0] fmt;
    logic [7:0] lpow;
    logic [7:0] sync_cfg;
    logic [7:0] opts;
    logic [7:0] win;
    logic [7:0] tune;
    logic [7:0] pre;
    logic [7:0] cap;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] sref_sync;
    logic [1:0] sync_sync;
    logic sref_prev;
    logic [1:0] pulse_cnt;
    logic aligned;
    logic [7:0] lock_cnt;
    logic lock;
    logic two_lane;
    logic range_err;
    logic [4:0] lmfc_cnt;
    logic [1:0] ilas_mf;
    link_sync_pkg::link_state_type st;
    logic nco_stb;
    logic div_rst;
    logic [15:0] nco_ph;
  } state_type;

  state_type q, d;

  // Integer IQ rate in ksps from converter clock and decimation
  function automatic int iq_ksps(input logic [7:0] dec);
    iq_ksps = (dec == 8'h00) ? 0 : CONV_CLK_KHZ / int'(dec);
  endfunction

  int iq_rate;
  int lanes;
  int lane_mbps;
  logic sref_rise;
  logic pulse_ok;
  logic fpmf_ok;

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.nco_stb = 1'b0;
    d.div_rst = 1'b0;
    iq_rate = iq_ksps(q.dec);
    lanes = (iq_rate >= link_sync_pkg::TWO_LANE_MIN_KSPS) ? 2 : 1;
    lane_mbps = (link_sync_pkg::LANE_RATE_FACTOR * (iq_rate / 1000)) / lanes;
    fpmf_ok = (lanes == 2) ? (FRAMES_PER_MF >= link_sync_pkg::FRAMES_MIN_F2)
                           : (FRAMES_PER_MF >= link_sync_pkg::FRAMES_MIN_F4);
    d.two_lane = (lanes == 2);
    d.range_err = (lane_mbps < link_sync_pkg::LANE_RATE_MIN_MBPS) ||
                  (lane_mbps > link_sync_pkg::LANE_RATE_MAX_MBPS) || !fpmf_ok ||
                  (iq_rate > link_sync_pkg::ONE_LANE_MAX_KSPS &&
                   iq_rate < link_sync_pkg::TWO_LANE_MIN_KSPS);
    // PLL relocks after any rate change
    if ((d.two_lane != q.two_lane) || (reg_req.wr && reg_req.addr ==
        link_sync_pkg::ADDR_DECIMATION_SELECT)) begin
      d.lock_cnt = '0;
      d.lock = 1'b0;
    end else if (d.range_err) begin
      d.lock = 1'b0;
    end else if (q.lock_cnt != link_sync_pkg::PLL_LOCK_CYCLES) begin
      d.lock_cnt = q.lock_cnt + 8'h01;
    end else begin
      d.lock = 1'b1;
    end
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        link_sync_pkg::ADDR_DECIMATION_SELECT: d.dec = reg_req.wdata;
        link_sync_pkg::ADDR_NCO_PHASE_LO: d.ph_lo = reg_req.wdata;
        link_sync_pkg::ADDR_NCO_PHASE_HI: d.ph_hi = reg_req.wdata;
        link_sync_pkg::ADDR_OUTPUT_FORMAT: d.fmt = reg_req.wdata;
        link_sync_pkg::ADDR_LANE_DRIVER_POWER: d.lpow = reg_req.wdata;
        link_sync_pkg::ADDR_SYNC_INPUT_CONFIG: d.sync_cfg = reg_req.wdata;
        link_sync_pkg::ADDR_SYSREF_OPTIONS: d.opts = reg_req.wdata;
        link_sync_pkg::ADDR_SYSREF_WINDOW: d.win = reg_req.wdata;
        link_sync_pkg::ADDR_LANE_TUNING: d.tune = reg_req.wdata;
        link_sync_pkg::ADDR_PREEMPHASIS: d.pre = reg_req.wdata;
        link_sync_pkg::ADDR_CAPTURE_PATH: d.cap = reg_req.wdata;
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      d.rvalid = 1'b1;
      unique case (reg_req.addr)
        link_sync_pkg::ADDR_DECIMATION_SELECT: d.rdata = q.dec;
        link_sync_pkg::ADDR_NCO_PHASE_LO: d.rdata = q.ph_lo;
        link_sync_pkg::ADDR_NCO_PHASE_HI: d.rdata = q.ph_hi;
        link_sync_pkg::ADDR_OUTPUT_FORMAT: d.rdata = q.fmt;
        link_sync_pkg::ADDR_LANE_DRIVER_POWER: d.rdata = q.lpow;
        link_sync_pkg::ADDR_SYNC_INPUT_CONFIG: d.rdata = q.sync_cfg;
        link_sync_pkg::ADDR_SYSREF_OPTIONS: d.rdata = q.opts;
        link_sync_pkg::ADDR_SYSREF_WINDOW: d.rdata = q.win;
        link_sync_pkg::ADDR_LANE_TUNING: d.rdata = q.tune;
        link_sync_pkg::ADDR_PREEMPHASIS: d.rdata = q.pre;
        link_sync_pkg::ADDR_CAPTURE_PATH: d.rdata = q.cap;
        link_sync_pkg::ADDR_PLL_STATUS: d.rdata = {6'h00, q.range_err, q.lock};
        default: d.rdata = 8'h00;
      endcase
    end
    // Two-flop synchronisers on both pins
    d.sref_sync = {q.sref_sync[0], sysref_in};
    d.sync_sync = {q.sync_sync[0], sync_request_in};
    // receiver off when host writes the disable value
    d.sref_prev = (q.sync_cfg == link_sync_pkg::SYSREF_RX_OFF_VALUE) ? 1'b0 : q.sref_sync[1];
    // rising edge on the sampled pulse
    sref_rise = q.sref_sync[1] && !q.sref_prev &&
                (q.sync_cfg != link_sync_pkg::SYSREF_RX_OFF_VALUE);
    // capture path bit must be low to act
    pulse_ok = sref_rise && q.opts[link_sync_pkg::OPT_ENABLE_BIT] &&
               !q.cap[link_sync_pkg::CAPTURE_REFCLK_BIT];
    if (pulse_ok) begin
      if (q.opts[link_sync_pkg::OPT_ONE_SHOT_BIT]) begin
        // act on second pulse, ignore later ones
        if (q.pulse_cnt != 2'h2) begin
          d.pulse_cnt = q.pulse_cnt + 2'h1;
        end
        if (q.pulse_cnt == 2'h1) begin
          d.div_rst = 1'b1;
        end
      end else begin
        // continuous pulses land in the window keep phase
        if (!q.aligned || (q.lmfc_cnt != 5'h00 &&
            !(q.win[link_sync_pkg::WIN_EARLY_BIT] && q.lmfc_cnt == 5'(FRAMES_PER_MF - 1)) &&
            !(q.win[link_sync_pkg::WIN_LATE_BIT] && q.lmfc_cnt == 5'h01))) begin
          d.div_rst = 1'b1;
        end
      end
    end
    // divider reset fixes multiframe phase and holds it
    if (d.div_rst) begin
      d.aligned = 1'b1;
      d.lmfc_cnt = '0;
      // oscillator phase loaded on the same pulse
      if (q.opts[link_sync_pkg::OPT_NCO_RESET_BIT]) begin
        d.nco_stb = 1'b1;
        d.nco_ph = {q.ph_hi, q.ph_lo};
      end
    end else if (q.lmfc_cnt == 5'(FRAMES_PER_MF - 1)) begin
      d.lmfc_cnt = '0;
    end else begin
      d.lmfc_cnt = q.lmfc_cnt + 5'h01;
    end
    // one link state for both lanes
    // Sync request forces comma phase whatever the reference receiver does
    if (!q.sync_sync[1]) begin
      d.st = link_sync_pkg::LINK_CGS;
    end else begin
      unique case (q.st)
        link_sync_pkg::LINK_CGS: d.st = link_sync_pkg::LINK_WAIT_LMFC;
        link_sync_pkg::LINK_WAIT_LMFC: begin
          if (q.lmfc_cnt == 5'(FRAMES_PER_MF - 1)) begin
            d.st = link_sync_pkg::LINK_ILAS;
            d.ilas_mf = '0;
          end
        end
        link_sync_pkg::LINK_ILAS: begin
          if (q.lmfc_cnt == 5'(FRAMES_PER_MF - 1)) begin
            d.ilas_mf = q.ilas_mf + 2'h1;
            if (q.ilas_mf == 2'h3) begin
              d.st = link_sync_pkg::LINK_DATA;
            end
          end
        end
        link_sync_pkg::LINK_DATA: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.dec <= link_sync_pkg::RST_DECIMATION;
      q.fmt <= link_sync_pkg::RST_OUTPUT_FORMAT;
      q.lpow <= link_sync_pkg::RST_LANE_POWER;
      q.sync_cfg <= link_sync_pkg::RST_SYNC_CONFIG;
      q.opts <= link_sync_pkg::RST_SYSREF_OPTIONS;
      q.pre <= link_sync_pkg::RST_PREEMPHASIS;
      q.cap <= link_sync_pkg::RST_CAPTURE_PATH;
      q.tune <= link_sync_pkg::RST_LANE_TUNING;
      q.st <= link_sync_pkg::LINK_CGS;
    end else begin
      q <= d;
    end
  end

  assign dummy_unused_n = '0;
  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign phy_ctrl = '{lane_power: q.lpow, format: q.fmt, preemph: q.pre, tuning: q.tune,
                      sync_lvds: q.sync_cfg[link_sync_pkg::SYNC_LVDS_BIT],
                      sync_term_en: q.sync_cfg[link_sync_pkg::SYNC_LVDS_BIT],
                      sysref_rx_en: q.sync_cfg != link_sync_pkg::SYSREF_RX_OFF_VALUE};
  assign two_lane_mode = q.two_lane;
  assign serdes_lock_flag = q.lock;
  assign nco_phase_load = q.nco_ph;
  assign nco_phase_strobe = q.nco_stb;
  assign divider_reset = q.div_rst;
  assign lane_send_comma = (q.st == link_sync_pkg::LINK_CGS) ? {q.two_lane, 1'b1} : 2'h0;
  assign lane_send_ilas = (q.st == link_sync_pkg::LINK_ILAS) ? {q.two_lane, 1'b1} : 2'h0;
  assign lane_octet = (q.st == link_sync_pkg::LINK_CGS) ? link_sync_pkg::OCTET_K28_5 : 8'h00;
endmodule // link_sync_ctrl

// ---- verification/link_sync_ctrl_chk.sv ----
// Purpose: Port checker for link_sync_ctrl
// Assumes: Single clock domain, async low reset
// Notes: Bound to the design below
`timescale 1ns/100ps
module link_sync_ctrl_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire link_sync_pkg::reg_req_type reg_req,
  input wire logic reg_rvalid,
  input wire logic sysref_in,
  input wire logic sync_request_in,
  input wire link_sync_pkg::phy_ctrl_type phy_ctrl,
  input wire logic two_lane_mode,
  input wire logic serdes_lock_flag,
  input wire logic nco_phase_strobe,
  input wire logic divider_reset,
  input wire logic [1:0] lane_send_comma,
  input wire logic [1:0] lane_send_ilas,
  input wire logic [7:0] lane_octet
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Synchroniser delay allowed for
  sequence s_req_low;
    (!sync_request_in) [*6];
  endsequence
  sequence s_released;
    (lane_send_comma[0] && sync_request_in) [*3];
  endsequence
  AST_READ_ANSWER:
    assert property (reg_req.rd |=> reg_rvalid) else $error("read not answered");
  AST_NO_STRAY_ANSWER:
    assert property (!reg_req.rd |=> !reg_rvalid) else $error("answer without read");
  AST_LVDS_TERM:
    assert property (phy_ctrl.sync_term_en == phy_ctrl.sync_lvds) else $error("termination");
  AST_DIV_PULSE:
    assert property (divider_reset |=> !divider_reset) else $error("divider reset too long");
  AST_NCO_WITH_DIV:
    assert property (nco_phase_strobe |-> divider_reset) else $error("phase load alone");
  AST_DIV_CAUSE:
    assert property (divider_reset |-> $past(sysref_in, 2) || $past(sysref_in, 3)
      || $past(sysref_in, 4)) else $error("divider reset without pulse");
  AST_CGS_ON_REQUEST:
    assert property (s_req_low |-> lane_send_comma[0]) else $error("no comma on request");
  AST_COMMA_OCTET:
    assert property (lane_send_comma[0] |-> lane_octet == link_sync_pkg::OCTET_K28_5)
      else $error("comma octet wrong");
  AST_ILAS_AFTER_RELEASE:
    assert property (s_released |-> ##[0:48] lane_send_ilas[0]) else $error("no alignment");
  AST_LANE_ONE:
    assert property (lane_send_comma[1] |-> two_lane_mode || $past(two_lane_mode))
      else $error("second lane in one-lane mode");
  AST_LOCK_CLEARED:
    assert property (reg_req.wr && reg_req.addr == link_sync_pkg::ADDR_DECIMATION_SELECT
      |-> ##2 !serdes_lock_flag) else $error("lock kept after rate change");
endmodule // link_sync_ctrl_chk

bind link_sync_ctrl link_sync_ctrl_chk u_chk (.clk, .arst_n, .reg_req, .reg_rvalid,
  .sysref_in, .sync_request_in, .phy_ctrl, .two_lane_mode, .serdes_lock_flag,
  .nco_phase_strobe, .divider_reset, .lane_send_comma, .lane_send_ilas, .lane_octet);

// ---- verification/link_rx_model.sv ----
// Purpose: Link receiver, drives the sync request
// Assumes: Commas counted on lane zero
// Notes: comma_goal sets a prompt or slow lock
`timescale 1ns/100ps
module link_rx_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic resync,
  input wire logic [7:0] comma_goal,
  input wire logic [7:0] lane_octet,
  output logic sync_request_in = 1'b0
);
  int seen = 0;
  always @(negedge clk or negedge arst_n) begin
    if (!arst_n || resync) begin
      seen <= 0;
      sync_request_in <= 1'b0;
    end else if (lane_octet == link_sync_pkg::OCTET_K28_5) begin
      seen <= seen + 1;
      if (seen >= comma_goal) sync_request_in <= 1'b1;
    end
  end
endmodule // link_rx_model

// ---- verification/jesd_link_config_sysref_sync_tb_top.sv ----
// Purpose: Self-checking bench for link_sync_ctrl
// Assumes: Receiver model on the link side
// Notes: Short multiframe keeps the run brief
`timescale 1ns/100ps
module jesd_link_config_sysref_sync_tb_top;
  import link_sync_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sysref_in = 1'b0;
  logic resync = 1'b0;
  logic [7:0] comma_goal = 8'h03;
  link_sync_pkg::reg_req_type reg_req = '0;
  link_sync_pkg::phy_ctrl_type phy_ctrl;
  logic [7:0] reg_rdata, lane_octet, rd_val, lo, hi;
  logic [15:0] nco_phase_load, nco_seen;
  logic [1:0] lane_send_comma, lane_send_ilas, e;
  logic reg_rvalid, sync_request_in, two_lane_mode, serdes_lock_flag;
  logic nco_phase_strobe, divider_reset;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_div = 0;
  int k;
  localparam logic [11:0] RA [8] = '{ADDR_DECIMATION_SELECT, ADDR_OUTPUT_FORMAT,
    ADDR_LANE_DRIVER_POWER, ADDR_SYNC_INPUT_CONFIG, ADDR_SYSREF_OPTIONS, ADDR_PREEMPHASIS,
    ADDR_CAPTURE_PATH, ADDR_LANE_TUNING};
  localparam logic [7:0] RV [8] = '{RST_DECIMATION, RST_OUTPUT_FORMAT, RST_LANE_POWER,
    RST_SYNC_CONFIG, RST_SYSREF_OPTIONS, RST_PREEMPHASIS, RST_CAPTURE_PATH, RST_LANE_TUNING};
  localparam int DECS [3] = '{8, 32, 16};
  initial begin
    forever #4 clk = ~clk;
  end
  link_sync_ctrl #(.FRAMES_PER_MF(9)) u_link_sync_ctrl (.clk, .arst_n, .reg_req,
    .dummy_unused_n(), .reg_rdata, .reg_rvalid, .sysref_in, .sync_request_in, .phy_ctrl,
    .two_lane_mode, .serdes_lock_flag, .nco_phase_load, .nco_phase_strobe, .divider_reset,
    .lane_send_comma, .lane_send_ilas, .lane_octet);
  link_rx_model u_link_rx_model (.clk, .arst_n, .resync, .comma_goal, .lane_octet,
    .sync_request_in);
  always @(posedge clk) begin
    if (divider_reset === 1'b1) n_div <= n_div + 1;
    if (nco_phase_strobe === 1'b1) nco_seen <= nco_phase_load;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(negedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    reg_req <= '0;
    if (reg_rvalid !== 1'b1) @(negedge clk);
    rd_val = reg_rdata;
  endtask
  task automatic pulse;
    @(negedge clk);
    sysref_in <= 1'b1;
    repeat (4) @(negedge clk);
    sysref_in <= 1'b0;
    repeat ($urandom_range(14, 30)) @(negedge clk);
  endtask
  task automatic wait_ilas;
    for (int i = 0; i < 400 && lane_send_ilas[0] !== 1'b1; i++) @(negedge clk);
  endtask
  // Returns range error and two-lane choice
  function automatic logic [1:0] rate_exp(input int dec);
    int iq = 3200000 / dec;
    int lanes = (iq >= TWO_LANE_MIN_KSPS) ? 2 : 1;
    int mbps = LANE_RATE_FACTOR * iq / lanes / 1000;
    return {mbps < LANE_RATE_MIN_MBPS || mbps > LANE_RATE_MAX_MBPS, lanes == 2};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Expected run is under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(29));
    repeat (20) @(negedge clk);
    arst_n <= 1'b1;
    wait_ilas();
    check("ilas lanes", 2'b11, lane_send_ilas);
    for (int i = 0; i < 100 && lane_send_ilas !== 2'b00; i++) @(negedge clk);
    check("data octet", 8'h00, lane_octet);
    comma_goal <= 8'd40;
    resync <= 1'b1;
    @(negedge clk);
    resync <= 1'b0;
    repeat (6) @(negedge clk);
    check("resync comma", {2'b11, OCTET_K28_5}, {lane_send_comma, lane_octet});
    wait_ilas();
    check("slow ilas", 1'b1, lane_send_ilas[0]);
    foreach (RA[i]) begin
      rd(RA[i]);
      check("reset value", RV[i], rd_val);
    end
    for (int i = 0; i < 12; i++) begin
      k = $urandom_range(1, 7);
      lo = $urandom;
      wr(RA[k], lo);
      rd(RA[k]);
      check("readback", lo, rd_val);
    end
    wr(12'h100, 8'h5a);
    rd(12'h100);
    check("unmapped", 8'h00, rd_val);
    wr(ADDR_SYNC_INPUT_CONFIG, SYSREF_RX_OFF_VALUE);
    check("lvds off rx", 3'b110, {phy_ctrl.sync_lvds, phy_ctrl.sync_term_en,
      phy_ctrl.sysref_rx_en});
    wr(ADDR_SYNC_INPUT_CONFIG, 8'h00);
    check("cmos rx", 3'b001, {phy_ctrl.sync_lvds, phy_ctrl.sync_term_en,
      phy_ctrl.sysref_rx_en});
    foreach (DECS[i]) begin
      wr(ADDR_DECIMATION_SELECT, DECS[i][7:0]);
      e = rate_exp(DECS[i]);
      rd(ADDR_PLL_STATUS);
      check("lock early", 1'b0, rd_val[0]);
      repeat (70) @(negedge clk);
      check("two lane", e[0], two_lane_mode);
      wr(ADDR_PLL_STATUS, 8'hfc);
      rd(ADDR_PLL_STATUS);
      check("range err", e[1], rd_val[1]);
      if (!e[1]) check("lock", 1'b1, rd_val[0]);
    end
    wr(ADDR_CAPTURE_PATH, RST_CAPTURE_PATH);
    wr(ADDR_SYSREF_OPTIONS, 8'h02);
    pulse();
    pulse();
    check("blocked", 0, n_div);
    lo = $urandom;
    hi = $urandom;
    wr(ADDR_NCO_PHASE_LO, lo);
    wr(ADDR_NCO_PHASE_HI, hi);
    wr(ADDR_CAPTURE_PATH, 8'h00);
    wr(ADDR_SYSREF_OPTIONS, 8'h26);
    pulse();
    check("first pulse", 0, n_div);
    pulse();
    pulse();
    check("one shot", 1, n_div);
    check("nco phase", {hi, lo}, nco_seen);
    results();
  end
endmodule // jesd_link_config_sysref_sync_tb_top
